// file: src/erpc_pkg.sv
// Purpose: Shared constants for the exception return address capture unit
// Assumes: 32-bit instruction addresses, 16-bit instruction width
// Notes: Cause field layout of the floating-point status/control word
package erpc_pkg;
   localparam int ADDR_W = 32;
   localparam int CAUSE_W = 6;
   localparam int FSCR_W = 32;
   // Cause field position inside the float status/control word
   localparam int CAUSE_LSB = 12;
   // Single shared event code used for every floating-point exception
   localparam logic [11:0] FPU_EVT_CODE = 12'h120;
   localparam logic [11:0] NO_EVT_CODE = 12'h000;
   localparam logic [ADDR_W-1:0] PC_RESET = 32'h0000_0000;
   localparam logic [FSCR_W-1:0] FSCR_RESET = 32'h0000_0000;
   // Exception class encodings
   localparam logic CLASS_REEXEC = 1'b0;
   localparam logic CLASS_COMPLETE = 1'b1;
endpackage : erpc_pkg

// file: src/erpc_capture.sv
// Purpose: Choose and hold the saved return address on an accepted event
// Assumes: Pipeline presents class, slot flags and addresses with accept
// Notes: Also merges floating-point causes into one shared event code
`timescale 1ns/1ns
`default_nettype none

module erpc_capture #(
   parameter int ADDR_W = erpc_pkg::ADDR_W,
   parameter int CAUSE_W = erpc_pkg::CAUSE_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Event acceptance from the pipeline
   input wire logic evt_accept,
   input wire logic evt_class,
   input wire logic evt_is_irq,
   input wire logic in_delay_slot,
   input wire logic in_delayed_branch,
   input wire logic [ADDR_W-1:0] pc_current,
   input wire logic [ADDR_W-1:0] pc_next,
   input wire logic [ADDR_W-1:0] pc_target,
   // Floating-point exception report
   input wire logic fpu_exc,
   input wire logic [CAUSE_W-1:0] fpu_cause,
   // Results
   output logic [ADDR_W-1:0] saved_return_pc,
   output logic saved_valid,
   output logic fpu_evt,
   output logic [11:0] evt_code,
   output logic [erpc_pkg::FSCR_W-1:0] float_status_control_reg
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   // Refuse widths that the capture register or the cause field cannot serve.
   // Any address width of at least one bit is fine; the reset address is sized to it on purpose.
   generate
      if (ADDR_W < 1) begin : g_bad_addr_w
         $error("erpc_capture: address width must be at least one bit");
      end
      if (CAUSE_W < 1) begin : g_bad_cause_w
         $error("erpc_capture: cause width must be at least one bit");
      end
      if (erpc_pkg::CAUSE_LSB + CAUSE_W > erpc_pkg::FSCR_W) begin : g_bad_cause_pos
         $error("erpc_capture: cause field runs past the status word");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Types

   // Capture state; HELD once any event has been taken since reset
   typedef enum logic [1:0] {
      ERPC_IDLE = 2'h1,
      ERPC_HELD = 2'h2
   } erpc_state_e;

   // Source of the saved address; one-hot so only one leg can ever win
   typedef enum logic [2:0] {
      ERPC_SRC_CUR = 3'h1,
      ERPC_SRC_NEXT = 3'h2,
      ERPC_SRC_TGT = 3'h4
   } erpc_src_e;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   // Event decode
   logic take_complete; // Completion-type exception or any interrupt
   logic take_target; // Completion exception raised by a delayed branch
   logic take_slot; // Re-execution exception raised in a delay slot
   erpc_src_e src_sel;
   logic [ADDR_W-1:0] pc_pick;

   // Capture group
   erpc_state_e state_q, state_d;
   logic [ADDR_W-1:0] pc_q, pc_d;
   logic valid_q, valid_d;

   // Float reporting group
   logic fpu_evt_q, fpu_evt_d;
   logic [11:0] code_q, code_d;
   logic [erpc_pkg::FSCR_W-1:0] fscr_q, fscr_d;
   logic [erpc_pkg::FSCR_W-1:0] cause_mask;
   logic [erpc_pkg::FSCR_W-1:0] cause_word;

   ////////////////////////////////////////////////////////////////////////////
   // Event classification

   // Interrupts count as completion events but never resume at a target.
   // A delay-slot fault keeps its own address so the slot runs again even
   // when the branch before it was not taken.
   // take_slot only names the delay-slot leg; it resolves to the same source.
   always_comb begin
      take_complete = evt_is_irq || (evt_class == erpc_pkg::CLASS_COMPLETE);
      take_target = take_complete && !evt_is_irq && in_delayed_branch;
      take_slot = !take_complete && in_delay_slot;
      src_sel = ERPC_SRC_CUR;
      if (take_target) begin
         src_sel = ERPC_SRC_TGT; // Branch destination, not the next address
      end else if (take_complete) begin
         src_sel = ERPC_SRC_NEXT; // Resume after the event
      end else if (take_slot) begin
         src_sel = ERPC_SRC_CUR; // Slot address, taken or not
      end else begin
         src_sel = ERPC_SRC_CUR; // Faulting instruction runs again
      end
   end

   // Address mux steered by the one-hot source select
   always_comb begin
      pc_pick = pc_current;
      if (src_sel == ERPC_SRC_TGT) begin
         pc_pick = pc_target;
      end else if (src_sel == ERPC_SRC_NEXT) begin
         pc_pick = pc_next;
      end else begin
         pc_pick = pc_current;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Return address capture

   // Next values of the capture group. Accept may come on back-to-back
   // cycles; each one overwrites the held address, so the handler always
   // sees the newest event.
   always_comb begin
      state_d = state_q;
      pc_d = pc_q;
      valid_d = valid_q;
      case (state_q)
         ERPC_IDLE: begin
            if (evt_accept) begin
               pc_d = pc_pick;
               valid_d = 1'b1;
               state_d = ERPC_HELD;
            end
         end
         ERPC_HELD: begin
            if (evt_accept) begin
               pc_d = pc_pick;
            end
         end
         default: begin
            // Stray code: fall back to idle with nothing held
            state_d = ERPC_IDLE;
            valid_d = 1'b0;
         end
      endcase
   end

   // Capture registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ERPC_IDLE;
         pc_q <= ADDR_W'(erpc_pkg::PC_RESET);
         valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         pc_q <= pc_d;
         valid_q <= valid_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Float exception reporting

   // Place the cause bits in their field of the status word, bit by bit
   for (genvar b = 0; b < erpc_pkg::FSCR_W; b++) begin : g_fscr_bit
      if (b >= erpc_pkg::CAUSE_LSB && b < erpc_pkg::CAUSE_LSB + CAUSE_W) begin : g_cause
         assign cause_mask[b] = 1'b1;
         assign cause_word[b] = fpu_cause[b - erpc_pkg::CAUSE_LSB];
      end else begin : g_other
         assign cause_mask[b] = 1'b0;
         assign cause_word[b] = 1'b0;
      end
   end

   // Every float cause raises the same event; software reads the status
   // word to tell them apart. Bits outside the cause field are left alone.
   // Back-to-back reports keep the event pulse high for each of them.
   always_comb begin
      fpu_evt_d = 1'b0;
      code_d = code_q;
      fscr_d = fscr_q;
      if (fpu_exc) begin
         fpu_evt_d = 1'b1; // One-cycle pulse per report
         code_d = erpc_pkg::FPU_EVT_CODE; // Same code for every cause
         fscr_d = (fscr_q & ~cause_mask) | cause_word;
      end
   end

   // Float reporting registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fpu_evt_q <= 1'b0;
         code_q <= erpc_pkg::NO_EVT_CODE;
         fscr_q <= erpc_pkg::FSCR_RESET;
      end else begin
         fpu_evt_q <= fpu_evt_d;
         code_q <= code_d;
         fscr_q <= fscr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops

   // saved_valid stays high from the first capture until the next reset
   assign saved_return_pc = pc_q;
   assign saved_valid = valid_q;
   assign fpu_evt = fpu_evt_q;
   assign evt_code = code_q;
   assign float_status_control_reg = fscr_q;

endmodule : erpc_capture
`default_nettype wire

// file: testbench/erpc_capture_assertions.sv
// Purpose: Checker for erpc_capture
// Assumes: Outputs answer one edge after the taken inputs
// Notes: Bound to every erpc_capture
`timescale 1ns/1ns
`default_nettype none
module erpc_chk #(parameter int ADDR_W = 32, parameter int CAUSE_W = 6) (
   input wire logic clk_sys, rst_n, evt_accept, evt_class, evt_is_irq, in_delayed_branch,
   input wire logic fpu_exc, fpu_evt, saved_valid, input wire logic [CAUSE_W-1:0] fpu_cause,
   input wire logic [ADDR_W-1:0] pc_current, pc_next, pc_target, saved_return_pc,
   input wire logic [31:0] float_status_control_reg, input wire logic [11:0] evt_code);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire cmp = evt_class | evt_is_irq;
   // Accepted events, sorted by the address they must leave behind
   sequence reexec_take_s;
      evt_accept && !cmp;
   endsequence
   sequence next_take_s;
      evt_accept && cmp && (evt_is_irq || !in_delayed_branch);
   endsequence
   sequence target_take_s;
      evt_accept && evt_class && !evt_is_irq && in_delayed_branch;
   endsequence
   reexec_pc_a: assert property (reexec_take_s |=>
      saved_return_pc == $past(pc_current)) else $error("reexec pc");
   cmpl_next_a: assert property (next_take_s |=>
      saved_return_pc == $past(pc_next)) else $error("next pc");
   branch_tgt_a: assert property (target_take_s |=>
      saved_return_pc == $past(pc_target)) else $error("target pc");
   capture_valid_a: assert property (evt_accept |=> saved_valid)
      else $error("valid");
   fpu_code_a: assert property (fpu_exc |=> fpu_evt && evt_code == erpc_pkg::FPU_EVT_CODE)
      else $error("fpu code");
   fpu_pulse_a: assert property (!fpu_exc |=> !fpu_evt) else $error("fpu pulse");
   fpu_cause_a: assert property (fpu_exc |=>
      float_status_control_reg[erpc_pkg::CAUSE_LSB +: CAUSE_W] == $past(fpu_cause))
      else $error("fpu cause");
endmodule : erpc_chk
bind erpc_capture erpc_chk #(.ADDR_W(ADDR_W), .CAUSE_W(CAUSE_W)) i_chk (.clk_sys, .rst_n,
   .evt_accept, .evt_class, .evt_is_irq, .in_delayed_branch, .fpu_exc, .fpu_evt, .fpu_cause,
   .pc_current, .pc_next, .pc_target, .saved_return_pc, .float_status_control_reg, .evt_code,
   .saved_valid);
`default_nettype wire

// file: testbench/erpc_pipe_model.sv
// Purpose: Pipeline model feeding random accepted events
// Assumes: Bench slices the word into the block's inputs
// Notes: Quiet while reset is low
`timescale 1ns/1ns
`default_nettype none
module erpc_pipe_model (input wire logic clk_sys, input wire logic rst_n,
   output var logic [127:0] stim);
   // Class, slot flags and addresses per event, changed off the sampling edge
   initial begin
      void'($urandom(47)); // One seed for the whole run, before any stimulus
      stim = '0;
      forever @(negedge clk_sys) begin
         stim <= rst_n ? {$urandom, $urandom, $urandom, $urandom} : '0;
      end
   end
endmodule : erpc_pipe_model
`default_nettype wire

// file: testbench/erpc_capture_tb.sv
// Purpose: Random self-checking bench for erpc_capture
// Assumes: Reference model updates on the same edge as the design
// Notes: Compares at the falling edge once outputs settled
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module erpc_capture_tb;
   logic clk_sys = 0, rst_n = 0, sv, fe;
   wire logic [127:0] s;
   logic [31:0] srp, fs, e_pc;
   logic [11:0] ec, e_ec;
   logic [5:0] e_c;
   logic e_f, e_v;
   int n_errors = 0, n_compared = 0;
   erpc_pipe_model i_erpc_pipe_model (.clk_sys(clk_sys), .rst_n(rst_n), .stim(s));
   erpc_capture i_erpc_capture (.clk_sys(clk_sys), .rst_n(rst_n), .evt_accept(s[0]),
      .evt_class(s[1]), .evt_is_irq(s[2] & s[3]), .in_delay_slot(s[4]), .in_delayed_branch(s[5]),
      .pc_current(s[63:32]), .pc_next(s[95:64]), .pc_target(s[127:96]), .fpu_exc(s[6]),
      .fpu_cause(s[12:7]), .saved_return_pc(srp), .saved_valid(sv), .fpu_evt(fe),
      .evt_code(ec), .float_status_control_reg(fs));
   initial forever #5 clk_sys = ~clk_sys;
   // Reference model of capture and float reporting
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) {e_pc, e_ec, e_c, e_f, e_v} = '0;
      else begin
         if (s[0]) e_pc = !(s[1] | (s[2] & s[3])) ? s[63:32] :
            (s[1] & !(s[2] & s[3]) & s[5]) ? s[127:96] : s[95:64];
         e_v = e_v | s[0];
         e_f = s[6];
         if (s[6]) {e_ec, e_c} = {erpc_pkg::FPU_EVT_CODE, s[12:7]};
      end
   end
   // Compare every settled cycle
   always @(negedge clk_sys) if (rst_n) begin
      `CHK("pc", e_pc, srp)
      `CHK("fpu_evt", e_f, fe)
      `CHK("code", e_ec, ec)
      `CHK("cause", e_c, fs[17:12])
      `CHK("fscr", 32'(e_c) << erpc_pkg::CAUSE_LSB, fs)
      `CHK("valid", e_v, sv)
   end
   task automatic print_verdict();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (5) @(negedge clk_sys);
      rst_n = 1;
      repeat (1500) @(negedge clk_sys);
      rst_n = 0; // Mid-run reset: outputs clear and capture restarts
      repeat (2) @(negedge clk_sys);
      rst_n = 1;
      repeat (1500) @(negedge clk_sys);
      print_verdict();
   end
   initial begin
      #60000;
      n_errors++;
      print_verdict();
   end
endmodule : erpc_capture_tb
`default_nettype wire
